//--- rtl/spc_pkg.sv
// Package: constants shared by the single preset counter control logic
package spc_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int MAX_RATE_HZ = 50;
	localparam int REM_RESP_MS = 10;
	localparam int DEB_US = 2000;
	localparam int DEB_CYCLES = CLK_HZ / 1_000_000 * DEB_US;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_PRESET = 8'h00;
	localparam logic [7:0] OFS_TIMED = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	// Status and control fields
	localparam int ST_OUT = 0;
	localparam int ST_MODE_OK = 1;
	localparam int ST_LOCKED = 2;
	localparam int ST_TEST = 3;
	localparam int ST_HOLD = 4;
	localparam int CT_TEST = 0;
	// ****************************************
	// Reset values and encodings
	// ****************************************
	localparam logic [23:0] PRESET_RST = 24'h00_0000;
	localparam logic [15:0] TIMED_DFLT = 16'h0010;
	localparam logic [3:0] MODE_LATCH = 4'h0;
	localparam logic [3:0] MODE_TIMED = 4'h1;
	localparam logic [3:0] MODE_AUTO = 4'h4;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_ZERO = 4'h0;
	localparam int DIGITS = 6;
	localparam int T_DIGITS = 4;
endpackage

//--- rtl/spc_debounce.sv
// Synchroniser and debounce filter for one active-low contact input
`timescale 1ns/1ps
module spc_debounce #(
	parameter int CYCLES = 40000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic raw_n,
	output logic clean_n
);
	localparam int CW = $clog2(CYCLES + 1);
	logic sync1_ff;
	logic sync2_ff;
	logic [CW-1:0] stab_ff;
	logic clean_ff;

	// Two-stage synchroniser; idle level is high (pulled up)
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
		end else begin
			sync1_ff <= raw_n;
			sync2_ff <= sync1_ff;
		end
	end

	// New level accepted only after it stays put; contact bounce never reaches the counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stab_ff <= '0;
			clean_ff <= 1'b1;
		end else if (sync2_ff == clean_ff) begin
			stab_ff <= '0;
		end else if (stab_ff == CW'(CYCLES - 1)) begin
			stab_ff <= '0;
			clean_ff <= sync2_ff;
		end else begin
			stab_ff <= stab_ff + 1'b1;
		end
	end

	assign clean_n = clean_ff;
endmodule

//--- rtl/spc_counter.sv
// Single preset up counter with latched or timed output and switch-selected mode
// Behaviour
// - Every pulse counted up to 50 Hz
// - One increment per low-going count input
// - Remote clear resets count, output within 10ms
// - Held clear keeps reset, ignores pulses
// - Lock refuses preset, timed writes, output test
// - Timed output 0.01 to 99.99 s
// - Default timed value 0.1 s
// - Front button acts only if switch enabled
// - Mode from four switch bits
// - Unsupported mode codes never drive output
// - Auto reset loses no pulse
// - Manual clear overrides every counter state
// - Mode 0: latch at preset, keep counting
// - Mode 1: timed output, keep counting
// - Mode 4: timed output, count back to zero
// - Timer retriggers across auto reset
// - Self-test never disturbs counting
// - Settings reloaded from nonvolatile store
`timescale 1ns/1ps
module spc_counter
	import spc_pkg::*;
#(
	parameter int DEB_CYC = DEB_CYCLES,
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic count_pulse_n,
	input wire logic remote_clear_n,
	input wire logic program_lock_n,
	input wire logic front_clear_n,
	input wire logic sw_clear_en,
	input wire logic [3:0] sw_mode,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic nv_valid,
	input wire logic [23:0] nv_preset,
	input wire logic [15:0] nv_timed,
	output logic [23:0] nv_preset_out,
	output logic [15:0] nv_timed_out,
	output logic nv_wr,
	output logic load_out,
	output logic [23:0] count_out
);
	localparam int TW = $clog2(TICK_CYC + 1);

	// ****************************************
	// Input conditioning
	// ****************************************
	logic cnt_lvl_n;
	logic rem_lvl_n;
	logic lock_lvl_n;
	logic btn_lvl_n;
	logic cnt_prev_ff;
	logic cnt_pulse;
	logic clear_act;
	logic locked;

	// Filter is far shorter than half a 50 Hz period, so no pulse is swallowed
	spc_debounce #(.CYCLES(DEB_CYC)) u_deb_cnt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raw_n(count_pulse_n),
		.clean_n(cnt_lvl_n)
	);
	// Remote clear path delay is the filter time, well under the 10ms response
	spc_debounce #(.CYCLES(DEB_CYC)) u_deb_rem (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raw_n(remote_clear_n),
		.clean_n(rem_lvl_n)
	);
	spc_debounce #(.CYCLES(DEB_CYC)) u_deb_lock (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raw_n(program_lock_n),
		.clean_n(lock_lvl_n)
	);
	spc_debounce #(.CYCLES(DEB_CYC)) u_deb_btn (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raw_n(front_clear_n),
		.clean_n(btn_lvl_n)
	);

	// Falling edge of the clean count level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_prev_ff <= 1'b1;
		end else begin
			cnt_prev_ff <= cnt_lvl_n;
		end
	end
	assign cnt_pulse = cnt_prev_ff & ~cnt_lvl_n;
	// Button is ignored unless the rear switch enables it
	assign clear_act = ~rem_lvl_n | (sw_clear_en & ~btn_lvl_n);
	assign locked = ~lock_lvl_n;

	// ****************************************
	// Mode decode
	// ****************************************
	logic mode_ok;
	logic timed_mode;
	logic auto_mode;
	// Four switch bits form the code; anything not listed still counts but never hits the preset
	assign mode_ok = (sw_mode == MODE_LATCH) | (sw_mode == MODE_TIMED) | (sw_mode == MODE_AUTO);
	assign timed_mode = (sw_mode == MODE_TIMED) | (sw_mode == MODE_AUTO);
	assign auto_mode = (sw_mode == MODE_AUTO);

	// ****************************************
	// Settings
	// ****************************************
	logic [23:0] preset_ff;
	logic [15:0] timed_ff;
	logic boot_ff;
	logic nv_wr_ff;
	logic test_ff;
	logic [DIGITS-1:0] wd_ok;
	logic [DIGITS-1:0] nvp_ok;
	logic [T_DIGITS-1:0] nvt_ok;
	logic wr_preset;
	logic wr_timed;
	logic nv_take;

	// Per-digit BCD validity of incoming values
	genvar gi;
	generate
		for (gi = 0; gi < DIGITS; gi++) begin : g_chk
			assign wd_ok[gi] = reg_wdata[4*gi+3:4*gi] <= BCD_MAX;
			assign nvp_ok[gi] = nv_preset[4*gi+3:4*gi] <= BCD_MAX;
			if (gi < T_DIGITS) begin : g_t
				assign nvt_ok[gi] = nv_timed[4*gi+3:4*gi] <= BCD_MAX;
			end
		end
	endgenerate

	// Preset and timed writes refused while locked; timed value must be nonzero BCD
	assign wr_preset = reg_wr & (reg_addr == OFS_PRESET) & ~locked & (&wd_ok);
	assign wr_timed = reg_wr & (reg_addr == OFS_TIMED) & ~locked & (&wd_ok[T_DIGITS-1:0])
		& (reg_wdata[15:0] != 16'h0000);
	// Stored image is taken once, just after reset release
	assign nv_take = boot_ff & nv_valid;

	// Preset value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			preset_ff <= PRESET_RST;
		end else if (wr_preset) begin
			preset_ff <= reg_wdata[23:0];
		end else if (nv_take & (&nvp_ok)) begin
			preset_ff <= nv_preset;
		end
	end

	// Timed output value; default stays unless a user value exists
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timed_ff <= TIMED_DFLT;
		end else if (wr_timed) begin
			timed_ff <= reg_wdata[15:0];
		end else if (nv_take & (&nvt_ok) & (nv_timed != 16'h0000)) begin
			timed_ff <= nv_timed;
		end
	end

	// Boot window and store strobe for the nonvolatile image
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_ff <= 1'b1;
			nv_wr_ff <= 1'b0;
		end else begin
			boot_ff <= 1'b0;
			nv_wr_ff <= wr_preset | wr_timed;
		end
	end

	// Self-test request; software may set it at any time
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			test_ff <= 1'b0;
		end else if (reg_wr & (reg_addr == OFS_CTRL)) begin
			test_ff <= reg_wdata[CT_TEST];
		end
	end

	// ****************************************
	// Six digit counter
	// ****************************************
	logic [23:0] cnt_ff;
	logic [23:0] nxt_cnt;
	logic [DIGITS:0] carry;
	logic hit;

	// Decimal ripple increment, one digit per entry
	assign carry[0] = 1'b1;
	generate
		for (gi = 0; gi < DIGITS; gi++) begin : g_inc
			wire [3:0] dig = cnt_ff[4*gi+3:4*gi];
			assign carry[gi+1] = carry[gi] & (dig == BCD_MAX);
			assign nxt_cnt[4*gi+3:4*gi] = !carry[gi] ? dig :
				(dig == BCD_MAX) ? BCD_ZERO : dig + 4'h1;
		end
	endgenerate

	// Preset event: full six-digit match of the incremented value
	assign hit = cnt_pulse & ~clear_act & mode_ok & (nxt_cnt == preset_ff);

	// Clear outranks everything; auto mode replaces the landing pulse with zero,
	// so the next pulse is counted normally
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (clear_act) begin
			cnt_ff <= '0;
		end else if (hit & auto_mode) begin
			cnt_ff <= '0;
		end else if (cnt_pulse) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// ****************************************
	// Output timer and latch
	// ****************************************
	logic latch_ff;
	logic [13:0] left_ff;
	logic [TW-1:0] tick_ff;
	logic [13:0] timed_bin;
	logic tick_end;
	logic out_state;
	logic test_on;

	// Hundredths of a second, BCD to binary
	assign timed_bin = 14'(timed_ff[15:12]) * 14'd1000 + 14'(timed_ff[11:8]) * 14'd100
		+ 14'(timed_ff[7:4]) * 14'd10 + 14'(timed_ff[3:0]);
	assign tick_end = (tick_ff == TW'(TICK_CYC - 1));

	// Latched output for mode 0
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff <= 1'b0;
		end else if (clear_act) begin
			latch_ff <= 1'b0;
		end else if (hit & (sw_mode == MODE_LATCH)) begin
			latch_ff <= 1'b1;
		end
	end

	// Timer reloads on every preset, even mid-run, so back-to-back presets
	// keep the output on without a gap
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_ff <= '0;
			tick_ff <= '0;
		end else if (clear_act) begin
			left_ff <= '0;
			tick_ff <= '0;
		end else if (hit & timed_mode) begin
			left_ff <= timed_bin;
			tick_ff <= '0;
		end else if (left_ff != 14'd0) begin
			tick_ff <= tick_end ? '0 : tick_ff + 1'b1;
			if (tick_end) begin
				left_ff <= left_ff - 14'd1;
			end
		end
	end

	// Test only forces the pin; counter and timer run untouched
	assign test_on = test_ff & ~locked;
	assign out_state = mode_ok & (latch_ff | (left_ff != 14'd0));
	assign load_out = out_state | test_on;
	assign count_out = cnt_ff;
	assign nv_preset_out = preset_ff;
	assign nv_timed_out = timed_ff;
	assign nv_wr = nv_wr_ff;

	// ****************************************
	// Register read port
	// ****************************************
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic [31:0] status;

	always_comb begin
		status = '0;
		status[ST_OUT] = out_state;
		status[ST_MODE_OK] = mode_ok;
		status[ST_LOCKED] = locked;
		status[ST_TEST] = test_on;
		status[ST_HOLD] = clear_act;
	end

	// Unmapped offsets read as zero
	always_comb begin
		case (reg_addr)
			OFS_PRESET: rd_mux = {8'h00, preset_ff};
			OFS_TIMED: rd_mux = {16'h0000, timed_ff};
			OFS_COUNT: rd_mux = {8'h00, cnt_ff};
			OFS_STATUS: rd_mux = status;
			OFS_CTRL: rd_mux = {31'h0000_0000, test_ff};
			default: rd_mux = '0;
		endcase
	end

	// Data valid only in the cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_ff;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_HOLD_CLEAR: assert property (clear_act |=> (cnt_ff == '0) && !out_state)
		else $error("count or output survived clear");
	AST_HOLD_NOCOUNT: assert property (clear_act && cnt_pulse |=> cnt_ff == '0)
		else $error("pulse counted during clear");
	AST_LOCK_PRESET: assert property (reg_wr && locked |=> $stable(preset_ff) && $stable(timed_ff))
		else $error("setting changed while locked");
	AST_LOCK_TEST: assert property (locked && !out_state |-> !load_out)
		else $error("output test while locked");
	AST_BAD_MODE: assert property (!mode_ok |-> !out_state)
		else $error("unsupported mode drove output");
	AST_LATCH_KEEP: assert property (sw_mode == MODE_LATCH && latch_ff && !clear_act |=> latch_ff)
		else $error("latched output dropped");
	AST_AUTO_WRAP: assert property (hit && auto_mode |=> cnt_ff == '0 && out_state)
		else $error("auto reset missed");
	AST_TIMER_LOAD: assert property (hit && timed_mode |=> left_ff == $past(timed_bin))
		else $error("timer not loaded");
	AST_COUNT_STEP: assert property (cnt_pulse && !clear_act && !hit |=> cnt_ff == $past(nxt_cnt))
		else $error("increment lost");
	AST_DIGIT_RANGE: assert property (cnt_ff[3:0] <= BCD_MAX && cnt_ff[23:20] <= BCD_MAX)
		else $error("count digit out of range");
	AST_RD_ONCE: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside its cycle");
endmodule

//--- tb/spc_contact_model.sv
// Contact closure and control switch model facing the counter's input pins
`timescale 1ns/1ps
module spc_contact_model (
	input wire logic sys_clk,
	output logic count_pulse_n,
	output logic remote_clear_n,
	output logic program_lock_n,
	output logic front_clear_n
);
	// ****************************************
	// Pin levels
	// ****************************************
	// All inputs have pull-ups, so a released contact reads high
	initial begin
		count_pulse_n = 1'b1;
		remote_clear_n = 1'b1;
		program_lock_n = 1'b1;
		front_clear_n = 1'b1;
	end
	// ****************************************
	// Actions
	// ****************************************
	// One closure: 8 cycles low then 8 high, the scaled top rate against a 4-cycle filter
	task automatic pulse();
		@(posedge sys_clk);
		count_pulse_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		count_pulse_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
	// Remote clear line held or released
	task automatic hold_clear(input logic on);
		@(posedge sys_clk);
		remote_clear_n <= ~on;
		repeat (10) @(posedge sys_clk);
	endtask
	// Lock line held or released
	task automatic lock(input logic on);
		@(posedge sys_clk);
		program_lock_n <= ~on;
		repeat (10) @(posedge sys_clk);
	endtask
	// Front button press long enough to pass the filter
	task automatic press();
		@(posedge sys_clk);
		front_clear_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		front_clear_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
	endtask
endmodule

//--- tb/test_spc_counter.sv
// Self-checking testbench for the single preset counter control logic
`timescale 1ns/1ps
module test_spc_counter;
	import spc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic count_pulse_n, remote_clear_n, program_lock_n, front_clear_n;
	logic sw_clear_en = 1'b0;
	logic [3:0] sw_mode = 4'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic load_out;
	logic [23:0] count_out;
	logic nv_valid = 1'b0;
	logic [23:0] nv_preset = 24'h00_0000;
	logic [15:0] nv_timed = 16'h0000;
	logic [23:0] nv_preset_out;
	logic [15:0] nv_timed_out;
	logic nv_wr;
	int errors = 0;
	int n_checks = 0;
	logic [31:0] rv;
	// ****************************************
	// Clock, design and partner
	// ****************************************
	// 20 MHz system clock
	always #25 sys_clk = ~sys_clk;
	// Short filter and tick keep the run brief; timings below derive from 4 and 5
	spc_counter #(.DEB_CYC(4), .TICK_CYC(5)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.count_pulse_n(count_pulse_n), .remote_clear_n(remote_clear_n), .program_lock_n(program_lock_n),
		.front_clear_n(front_clear_n), .sw_clear_en(sw_clear_en), .sw_mode(sw_mode), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_valid(nv_valid),
		.nv_preset(nv_preset), .nv_timed(nv_timed), .nv_preset_out(nv_preset_out),
		.nv_timed_out(nv_timed_out), .nv_wr(nv_wr),
		.load_out(load_out), .count_out(count_out));
	spc_contact_model model (.sys_clk(sys_clk), .count_pulse_n(count_pulse_n), .remote_clear_n(remote_clear_n),
		.program_lock_n(program_lock_n), .front_clear_n(front_clear_n));
	// ****************************************
	// Shared tasks
	// ****************************************
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle read strobe; data is taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Clear pulse between scenarios
	task automatic clr();
		model.hold_clear(1'b1);
		model.hold_clear(1'b0);
	endtask
	// Judge count and output together
	task automatic look(input logic [23:0] c, input logic l);
		chk({8'h00, count_out}, {8'h00, c});
		chk({31'h0, load_out}, {31'h0, l});
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Reset values and an unmapped address
	task automatic t_defaults();
		rd(OFS_PRESET, rv);
		chk(rv, 32'h0000_0000);
		rd(OFS_TIMED, rv);
		chk(rv, 32'h0000_0010);
		rd(8'h20, rv);
		chk(rv, 32'h0000_0000);
		look(24'h00_0000, 1'b0);
	endtask
	// Latch at preset, keep counting, clear held ignores pulses
	task automatic t_mode0();
		sw_mode <= MODE_LATCH;
		wr(OFS_PRESET, 32'h0000_0003);
		repeat (2) model.pulse();
		look(24'h00_0002, 1'b0);
		model.pulse();
		look(24'h00_0003, 1'b1);
		model.pulse();
		look(24'h00_0004, 1'b1);
		model.hold_clear(1'b1);
		look(24'h00_0000, 1'b0);
		model.pulse();
		look(24'h00_0000, 1'b0);
		model.hold_clear(1'b0);
	endtask
	// Timed output of 5 hundredths, counting carries on
	task automatic t_mode1();
		sw_mode <= MODE_TIMED;
		wr(OFS_TIMED, 32'h0000_0005);
		wr(OFS_PRESET, 32'h0000_0002);
		repeat (2) model.pulse();
		look(24'h00_0002, 1'b1);
		repeat (25) @(posedge sys_clk);
		look(24'h00_0002, 1'b0);
		model.pulse();
		look(24'h00_0003, 1'b0);
		clr();
		look(24'h00_0000, 1'b0);
	endtask
	// Auto reset at preset, output runs across the reset
	task automatic t_mode4();
		sw_mode <= MODE_AUTO;
		wr(OFS_TIMED, 32'h0000_0080);
		repeat (2) model.pulse();
		look(24'h00_0000, 1'b1);
		model.pulse();
		look(24'h00_0001, 1'b1);
		model.pulse();
		look(24'h00_0000, 1'b1);
		clr();
		look(24'h00_0000, 1'b0);
	endtask
	// Lock refuses writes and output test; test runs once unlocked
	task automatic t_lock();
		model.lock(1'b1);
		wr(OFS_PRESET, 32'h0000_0009);
		rd(OFS_PRESET, rv);
		chk(rv, 32'h0000_0002);
		wr(OFS_TIMED, 32'h0000_0033);
		rd(OFS_TIMED, rv);
		chk(rv, 32'h0000_0080);
		wr(OFS_CTRL, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, load_out}, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0000);
		model.lock(1'b0);
		wr(OFS_CTRL, 32'h0000_0001);
		model.pulse();
		look(24'h00_0001, 1'b1);
		wr(OFS_CTRL, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		look(24'h00_0001, 1'b0);
	endtask
	// Front button only with its switch on
	task automatic t_front();
		sw_clear_en <= 1'b0;
		model.press();
		look(24'h00_0001, 1'b0);
		sw_clear_en <= 1'b1;
		model.press();
		look(24'h00_0000, 1'b0);
	endtask
	// Unsupported codes count but never switch the output on
	task automatic t_badmode();
		logic [3:0] codes [3];
		codes = '{4'h2, 4'h3, 4'h5};
		wr(OFS_PRESET, 32'h0000_0001);
		foreach (codes[i]) begin
			sw_mode <= codes[i];
			clr();
			model.pulse();
			look(24'h00_0001, 1'b0);
		end
	endtask
	// Store port follows accepted writes only; after a mid-run reset the stored preset loads and a zero stored timed value is refused
	task automatic t_store();
		sw_mode <= MODE_LATCH;
		wr(OFS_TIMED, 32'h0000_0000);
		#1 chk({31'h0, nv_wr}, 32'h0000_0000);
		wr(OFS_PRESET, 32'h0000_000A);
		#1 chk({31'h0, nv_wr}, 32'h0000_0000);
		wr(OFS_TIMED, 32'h0000_0250);
		#1 chk({31'h0, nv_wr}, 32'h0000_0001);
		chk({16'h0000, nv_timed_out}, 32'h0000_0250);
		chk({8'h00, nv_preset_out}, 32'h0000_0001);
		rd(OFS_COUNT, rv);
		chk(rv, 32'h0000_0001);
		rd(OFS_STATUS, rv);
		chk(rv, 32'h0000_0002);
		@(posedge sys_clk);
		#1 chk(reg_rdata, 32'h0000_0000);
		@(posedge sys_clk);
		nv_valid <= 1'b1;
		nv_preset <= 24'h12_3456;
		nv_timed <= 16'h0000;
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		nv_valid <= 1'b0;
		rd(OFS_PRESET, rv);
		chk(rv, 32'h0012_3456);
		rd(OFS_TIMED, rv);
		chk(rv, 32'h0000_0010);
		look(24'h00_0000, 1'b0);
	endtask
	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_defaults();
		t_mode0();
		t_mode1();
		t_mode4();
		t_lock();
		t_front();
		t_badmode();
		t_store();
		close_out();
	end
	// Whole run needs about 560 cycles; 20000 means a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		close_out();
	end
endmodule
